// file: rtl/uds_pkg.sv
/*
 * Shared constants and types for the USB device receive status block:
 * register indices, bit positions, reset values, buffer indices and state.
 * Assumes a byte-wide register port and a single 100 MHz system clock.
 */
package uds_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices on the plain register port
    localparam logic [7:0] ADDR_PKT_ERR    = 8'h00;
    localparam logic [7:0] ADDR_FIFO_LOW   = 8'h01;
    localparam logic [7:0] ADDR_FIFO_HIGH  = 8'h02;
    localparam logic [7:0] ADDR_FRAME_HIGH = 8'h03;
    localparam logic [7:0] ADDR_FRAME_LOW  = 8'h04;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int ERR_PID       = 3;
    localparam int ERR_ADDR_CRC  = 2;
    localparam int ERR_DATA_CRC  = 1;
    localparam int ERR_STUFF     = 0;
    localparam int LOW_EP1_EMPTY = 3;
    localparam int LOW_EP1_FULL  = 2;
    localparam int LOW_RX0_EMPTY = 1;
    localparam int LOW_RX0_FULL  = 0;
    localparam int HI_EP3_EMPTY  = 5;
    localparam int HI_EP3_FULL   = 4;
    localparam int HI_EP2_EMPTY  = 3;
    localparam int HI_EP2_FULL   = 2;
    localparam int HI_TX0_EMPTY  = 1;
    localparam int HI_TX0_FULL   = 0;
    localparam int FRAME_W       = 11;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [7:0]  PKT_ERR_RST   = 8'h00;
    localparam logic [7:0]  FIFO_LOW_RST  = 8'h0A;
    localparam logic [7:0]  FIFO_HIGH_RST = 8'h2A;
    localparam logic [10:0] FRAME_RST     = 11'h000;
    localparam logic [1:0]  RST_SYNC_RST  = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Endpoint buffers, counted in bytes
    localparam int NUM_BUFS    = 7;
    localparam int CNT_W       = 9;
    localparam int SMALL_DEPTH = 64;
    localparam int LARGE_DEPTH = 256;
    localparam int BUF_RX0     = 0;
    localparam int BUF_TX0     = 1;
    localparam int BUF_EP1     = 2;
    localparam int BUF_EP2_A   = 3;
    localparam int BUF_EP2_B   = 4;
    localparam int BUF_EP3_A   = 5;
    localparam int BUF_EP3_B   = 6;

    typedef logic [NUM_BUFS-1:0][CNT_W-1:0] uds_cnt_t;

    typedef struct packed {
        logic [1:0]         rst_sync;
        logic [3:0]         err;
        uds_cnt_t           cnt;
        logic [FRAME_W-1:0] frame;
        logic [7:0]         rd_data;
    } uds_state_s;

endpackage : uds_pkg

// file: rtl/uds_rx_status.sv
/*
 * USB device receive status: packet error flags, endpoint buffer
 * empty/full flags and the captured start-of-frame number, all read
 * over a plain byte-wide register port.
 * Assumes the packet engine and buffer logic run on clk_sys and give
 * one-cycle event pulses; arst_n may come from anywhere.
 */
// What this block does
// RL1: Read-only packet error register, bits 3..0 pid, address crc, data crc, stuff.
// RL2: Set pid error on a bad packet identifier; clear when host resends.
// RL3: Set address crc error on failed token crc; clear when host resends.
// RL4: Set data crc error on failed data crc; clear when host resends.
// RL5: Set bit-stuff error on stuffing violation; clear when host resends.
// RL6: Unused bit positions in all status registers read as zero.
// RL7: Buffer status registers reset to 0x0A and 0x2A, read-only.
// RL8: Endpoint 1 empty while its buffer is empty; drops on any data in.
// RL9: Endpoint 1 full when its 64-byte buffer is full.
// RL10: Endpoint 0 receive empty while empty; drops when data is received.
// RL11: Endpoint 0 receive full when its 64-byte buffer is full.
// RL12: Endpoint 3 empty while its buffers are empty; drops on data in.
// RL13: Endpoint 3 full when either paired 256-byte buffer is full.
// RL14: Endpoint 2 empty while its buffers are empty; drops on data in.
// RL15: Endpoint 2 full when either paired 64-byte buffer is full.
// RL16: Endpoint 0 transmit empty while empty; drops on processor write.
// RL17: Endpoint 0 transmit full when its 64-byte buffer is full.
// RL18: Eleven-bit frame number in high (3 bits) and low (8 bits) registers.
// RL19: Frame number captured from start-of-frame packets in isochronous mode.
// RL20: Only error-free start-of-frame packets update the frame number.
// RL21: Processor writes to these registers are ignored.
module uds_rx_status #(
    parameter int SMALL_DEPTH = uds_pkg::SMALL_DEPTH,
    parameter int LARGE_DEPTH = uds_pkg::LARGE_DEPTH
) (
    input  wire logic                          clk_sys,
    input  wire logic                          arst_n,
    input  wire logic                          usb_bus_reset,
    input  wire logic                          resend_start,
    input  wire logic                          pid_error,
    input  wire logic                          addr_crc_error,
    input  wire logic                          data_crc_error,
    input  wire logic                          stuff_error,
    input  wire logic [uds_pkg::NUM_BUFS-1:0]  buf_push,
    input  wire logic [uds_pkg::NUM_BUFS-1:0]  buf_pop,
    input  wire logic                          iso_mode,
    input  wire logic                          sof_valid,
    input  wire logic                          sof_crc_ok,
    input  wire logic [uds_pkg::FRAME_W-1:0]   sof_frame,
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [7:0]                    reg_wr_data,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [7:0]                    reg_rd_data
);

    ////////////////////////////////////////////////////////////////////////
    // State

    uds_pkg::uds_state_s st;
    uds_pkg::uds_state_s next_st;
    logic                clear_all;
    logic [7:0]          fifo_low;
    logic [7:0]          fifo_high;

    function automatic logic [uds_pkg::CNT_W-1:0] buf_depth(input int idx);
        if (idx >= uds_pkg::BUF_EP3_A) begin
            buf_depth = uds_pkg::CNT_W'(LARGE_DEPTH);
        end else begin
            buf_depth = uds_pkg::CNT_W'(SMALL_DEPTH);
        end
    endfunction : buf_depth

    function automatic logic buf_full(input uds_pkg::uds_cnt_t cnt, input int idx);
        buf_full = (cnt[idx] == buf_depth(idx));
    endfunction : buf_full

    function automatic logic buf_empty(input uds_pkg::uds_cnt_t cnt, input int idx);
        buf_empty = (cnt[idx] == '0);
    endfunction : buf_empty

    ////////////////////////////////////////////////////////////////////////
    // Status bytes, built from the byte counts

    always_comb begin
        fifo_low  = 8'h00;                                                       // [RL6]
        fifo_high = 8'h00;                                                       // [RL6]
        fifo_low[uds_pkg::LOW_EP1_EMPTY] = buf_empty(st.cnt, uds_pkg::BUF_EP1);  // [RL8]
        fifo_low[uds_pkg::LOW_EP1_FULL]  = buf_full(st.cnt, uds_pkg::BUF_EP1);   // [RL9]
        fifo_low[uds_pkg::LOW_RX0_EMPTY] = buf_empty(st.cnt, uds_pkg::BUF_RX0);  // [RL10]
        fifo_low[uds_pkg::LOW_RX0_FULL]  = buf_full(st.cnt, uds_pkg::BUF_RX0);   // [RL11]
        // Paired buffers: empty only when both are, full when either is
        fifo_high[uds_pkg::HI_EP3_EMPTY] = buf_empty(st.cnt, uds_pkg::BUF_EP3_A)
                                         & buf_empty(st.cnt, uds_pkg::BUF_EP3_B); // [RL12]
        fifo_high[uds_pkg::HI_EP3_FULL]  = buf_full(st.cnt, uds_pkg::BUF_EP3_A)
                                         | buf_full(st.cnt, uds_pkg::BUF_EP3_B);  // [RL13]
        fifo_high[uds_pkg::HI_EP2_EMPTY] = buf_empty(st.cnt, uds_pkg::BUF_EP2_A)
                                         & buf_empty(st.cnt, uds_pkg::BUF_EP2_B); // [RL14]
        fifo_high[uds_pkg::HI_EP2_FULL]  = buf_full(st.cnt, uds_pkg::BUF_EP2_A)
                                         | buf_full(st.cnt, uds_pkg::BUF_EP2_B);  // [RL15]
        fifo_high[uds_pkg::HI_TX0_EMPTY] = buf_empty(st.cnt, uds_pkg::BUF_TX0);  // [RL16]
        fifo_high[uds_pkg::HI_TX0_FULL]  = buf_full(st.cnt, uds_pkg::BUF_TX0);   // [RL17]
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    // Bus reset is taken like any input: events in its cycle are lost on purpose
    assign clear_all = !st.rst_sync[1] || usb_bus_reset;

    always_comb begin
        next_st          = st;
        next_st.rst_sync = {st.rst_sync[0], 1'b1};

        // Clear first so that an error in the same cycle still lands
        if (resend_start) begin
            next_st.err = 4'h0;                                      // [RL2] [RL3] [RL4] [RL5]
        end
        if (pid_error) begin
            next_st.err[uds_pkg::ERR_PID] = 1'b1;                    // [RL2]
        end
        if (addr_crc_error) begin
            next_st.err[uds_pkg::ERR_ADDR_CRC] = 1'b1;               // [RL3]
        end
        if (data_crc_error) begin
            next_st.err[uds_pkg::ERR_DATA_CRC] = 1'b1;               // [RL4]
        end
        if (stuff_error) begin
            next_st.err[uds_pkg::ERR_STUFF] = 1'b1;                  // [RL5]
        end

        // A push into a full buffer or a pop from an empty one is dropped
        for (int i = 0; i < uds_pkg::NUM_BUFS; i++) begin
            if (buf_push[i] && !buf_full(st.cnt, i)
                && !(buf_pop[i] && !buf_empty(st.cnt, i))) begin
                next_st.cnt[i] = st.cnt[i] + 9'h001;                 // [RL8] [RL10] [RL16]
            end else if (buf_pop[i] && !buf_empty(st.cnt, i)
                         && !(buf_push[i] && !buf_full(st.cnt, i))) begin
                next_st.cnt[i] = st.cnt[i] - 9'h001;
            end
        end

        // Damaged start-of-frame packets leave the old number standing
        if (sof_valid && sof_crc_ok && iso_mode) begin
            next_st.frame = sof_frame;                               // [RL19] [RL20]
        end

        // Writes have no path into the state at all
        next_st.rd_data = 8'h00;                                     // [RL21]
        if (reg_rd) begin
            if (reg_addr == uds_pkg::ADDR_PKT_ERR) begin
                next_st.rd_data = {4'h0, st.err};                    // [RL1] [RL6]
            end else if (reg_addr == uds_pkg::ADDR_FIFO_LOW) begin
                next_st.rd_data = fifo_low;
            end else if (reg_addr == uds_pkg::ADDR_FIFO_HIGH) begin
                next_st.rd_data = fifo_high;
            end else if (reg_addr == uds_pkg::ADDR_FRAME_HIGH) begin
                next_st.rd_data = {5'h00, st.frame[10:8]};           // [RL18] [RL6]
            end else if (reg_addr == uds_pkg::ADDR_FRAME_LOW) begin
                next_st.rd_data = st.frame[7:0];                     // [RL18]
            end else begin
                next_st.rd_data = 8'h00;
            end
        end

        // System or bus reset: counts to zero gives 0x0A and 0x2A
        if (clear_all) begin
            next_st.err   = uds_pkg::PKT_ERR_RST[3:0];               // [RL1]
            next_st.cnt   = '0;                                      // [RL7]
            next_st.frame = uds_pkg::FRAME_RST;                      // [RL18]
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st.rst_sync <= uds_pkg::RST_SYNC_RST;
            st.err      <= uds_pkg::PKT_ERR_RST[3:0];
            st.cnt      <= '0;
            st.frame    <= uds_pkg::FRAME_RST;
            st.rd_data  <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    // Zero outside the cycle after a read, so an idle port never shows stale data
    assign reg_rd_data = st.rd_data;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys);
    endclocking

    default disable iff (!st.rst_sync[1]);

    a_pid_flag_set: assert property (                                        // [RL2]
        pid_error && !usb_bus_reset |=> st.err[uds_pkg::ERR_PID])
        else $error("pid error flag not set after a bad identifier");

    a_acrc_flag_set: assert property (                                       // [RL3]
        addr_crc_error && !usb_bus_reset |=> st.err[uds_pkg::ERR_ADDR_CRC])
        else $error("address crc flag not set");

    a_dcrc_flag_set: assert property (                                       // [RL4]
        data_crc_error && !usb_bus_reset |=> st.err[uds_pkg::ERR_DATA_CRC])
        else $error("data crc flag not set");

    a_stuff_flag_set: assert property (                                      // [RL5]
        stuff_error && !usb_bus_reset |=> st.err[uds_pkg::ERR_STUFF])
        else $error("bit stuff flag not set");

    a_err_resend_clear: assert property (                                    // [RL2]
        resend_start && !(pid_error || addr_crc_error || data_crc_error
        || stuff_error) && !usb_bus_reset |=> st.err == 4'h0)
        else $error("error flags not cleared by resend");

    a_err_hold: assert property (                                            // [RL1]
        !resend_start && !usb_bus_reset |=> (st.err & $past(st.err)) == $past(st.err))
        else $error("error flag dropped without resend or reset");

    a_upper_bits_zero: assert property (                                     // [RL6]
        reg_rd && reg_addr == uds_pkg::ADDR_FRAME_HIGH |=> reg_rd_data[7:3] == 5'h00)
        else $error("unused frame high bits read as one");

    a_bus_reset_values: assert property (                                    // [RL7]
        usb_bus_reset |=> fifo_low == uds_pkg::FIFO_LOW_RST
        && fifo_high == uds_pkg::FIFO_HIGH_RST && st.frame == uds_pkg::FRAME_RST)
        else $error("status not at reset values after bus reset");

    a_ep1_empty_drop: assert property (                                      // [RL8]
        buf_push[uds_pkg::BUF_EP1] && !usb_bus_reset |=> !fifo_low[uds_pkg::LOW_EP1_EMPTY])
        else $error("endpoint 1 still empty after data in");

    a_tx0_full_rise: assert property (                                       // [RL17]
        st.cnt[uds_pkg::BUF_TX0] == 9'(SMALL_DEPTH - 1) && buf_push[uds_pkg::BUF_TX0]
        && !buf_pop[uds_pkg::BUF_TX0] && !usb_bus_reset
        |=> fifo_high[uds_pkg::HI_TX0_FULL])
        else $error("transmit buffer full flag late");

    a_frame_load: assert property (                                          // [RL19]
        sof_valid && sof_crc_ok && iso_mode && !usb_bus_reset
        |=> st.frame == $past(sof_frame))
        else $error("frame number not captured");

    a_frame_keep_bad: assert property (                                      // [RL20]
        sof_valid && !sof_crc_ok && !usb_bus_reset |=> $stable(st.frame))
        else $error("frame number changed on a damaged packet");

    a_write_ignored: assert property (                                       // [RL21]
        reg_wr && !sof_valid && !usb_bus_reset |=> $stable(st.frame))
        else $error("write changed the frame number");

    ////////////////////////////////////////////////////////////////////////
    // Error flags and register reads

    a_err_bus_reset: assert property (  // [RL1]
        usb_bus_reset |=> st.err == 4'h0)
        else $error("error flags survive a bus reset");

    a_err_read_back: assert property (  // [RL1]
        reg_rd && reg_addr == uds_pkg::ADDR_PKT_ERR |=> reg_rd_data == {4'h0, $past(st.err)})
        else $error("packet error read differs from the flags");

    a_write_keeps_flags: assert property (  // [RL21]
        reg_wr && !resend_start && !usb_bus_reset && !(pid_error || addr_crc_error
        || data_crc_error || stuff_error) |=> $stable(st.err))
        else $error("write changed the error flags");

    a_idle_read_zero: assert property (  // [RL6]
        !reg_rd |=> reg_rd_data == 8'h00)
        else $error("read data not zero outside a read");

    a_unmapped_zero: assert property (  // [RL6]
        reg_rd && reg_addr > uds_pkg::ADDR_FRAME_LOW |=> reg_rd_data == 8'h00)
        else $error("unmapped read not zero");

    a_fifo_low_upper: assert property (  // [RL6]
        reg_rd && reg_addr == uds_pkg::ADDR_FIFO_LOW |=> reg_rd_data[7:4] == 4'h0)
        else $error("unused low buffer status bits read as one");

    a_fifo_high_upper: assert property (  // [RL6]
        reg_rd && reg_addr == uds_pkg::ADDR_FIFO_HIGH |=> reg_rd_data[7:6] == 2'h0)
        else $error("unused high buffer status bits read as one");

    ////////////////////////////////////////////////////////////////////////
    // Buffer flags

    a_rx0_empty_drop: assert property (  // [RL10]
        buf_push[uds_pkg::BUF_RX0] && !usb_bus_reset |=> !fifo_low[uds_pkg::LOW_RX0_EMPTY])
        else $error("endpoint 0 receive still empty after data in");

    a_tx0_empty_drop: assert property (  // [RL16]
        buf_push[uds_pkg::BUF_TX0] && !usb_bus_reset |=> !fifo_high[uds_pkg::HI_TX0_EMPTY])
        else $error("endpoint 0 transmit still empty after a write");

    a_ep2_empty_drop: assert property (  // [RL14]
        (buf_push[uds_pkg::BUF_EP2_A] || buf_push[uds_pkg::BUF_EP2_B]) && !usb_bus_reset
        |=> !fifo_high[uds_pkg::HI_EP2_EMPTY])
        else $error("endpoint 2 still empty after data in");

    a_ep3_empty_drop: assert property (  // [RL12]
        (buf_push[uds_pkg::BUF_EP3_A] || buf_push[uds_pkg::BUF_EP3_B]) && !usb_bus_reset
        |=> !fifo_high[uds_pkg::HI_EP3_EMPTY])
        else $error("endpoint 3 still empty after data in");

    a_ep1_full_rise: assert property (  // [RL9]
        st.cnt[uds_pkg::BUF_EP1] == 9'(SMALL_DEPTH - 1) && buf_push[uds_pkg::BUF_EP1]
        && !buf_pop[uds_pkg::BUF_EP1] && !usb_bus_reset |=> fifo_low[uds_pkg::LOW_EP1_FULL])
        else $error("endpoint 1 full flag late");

    a_rx0_full_rise: assert property (  // [RL11]
        st.cnt[uds_pkg::BUF_RX0] == 9'(SMALL_DEPTH - 1) && buf_push[uds_pkg::BUF_RX0]
        && !buf_pop[uds_pkg::BUF_RX0] && !usb_bus_reset |=> fifo_low[uds_pkg::LOW_RX0_FULL])
        else $error("endpoint 0 receive full flag late");

    a_ep2_full_rise: assert property (  // [RL15]
        st.cnt[uds_pkg::BUF_EP2_B] == 9'(SMALL_DEPTH - 1) && buf_push[uds_pkg::BUF_EP2_B]
        && !buf_pop[uds_pkg::BUF_EP2_B] && !usb_bus_reset |=> fifo_high[uds_pkg::HI_EP2_FULL])
        else $error("endpoint 2 full flag late");

    a_ep3_full_rise: assert property (  // [RL13]
        st.cnt[uds_pkg::BUF_EP3_A] == 9'(LARGE_DEPTH - 1) && buf_push[uds_pkg::BUF_EP3_A]
        && !buf_pop[uds_pkg::BUF_EP3_A] && !usb_bus_reset |=> fifo_high[uds_pkg::HI_EP3_FULL])
        else $error("endpoint 3 full flag late");

    a_ep1_count_bound: assert property (  // [RL9]
        st.cnt[uds_pkg::BUF_EP1] <= 9'(SMALL_DEPTH))
        else $error("endpoint 1 count beyond its depth");

    ////////////////////////////////////////////////////////////////////////
    // Frame number

    a_frame_keep_noiso: assert property (  // [RL19]
        sof_valid && !iso_mode && !usb_bus_reset |=> $stable(st.frame))
        else $error("frame number taken outside isochronous mode");

    a_frame_high_read: assert property (  // [RL18]
        reg_rd && reg_addr == uds_pkg::ADDR_FRAME_HIGH
        |=> reg_rd_data[2:0] == $past(st.frame[10:8]))
        else $error("frame high read differs from the stored number");

    a_frame_low_read: assert property (  // [RL18]
        reg_rd && reg_addr == uds_pkg::ADDR_FRAME_LOW
        |=> reg_rd_data == $past(st.frame[7:0]))
        else $error("frame low read differs from the stored number");

endmodule : uds_rx_status

// file: testbench/uds_host_model.sv
/*
 * Behavioural model of the USB host side as the packet engine reports it:
 * error pulses, resend starts and start-of-frame packets.
 * Assumes the caller invokes one task at a time, from the bench clock domain.
 */
module uds_host_model (
    input  wire logic        clk_sys,
    output logic      [3:0]  err_ev,
    output logic             resend_start,
    output logic             sof_valid,
    output logic             sof_crc_ok,
    output logic      [10:0] sof_frame
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        err_ev       = 4'h0;
        resend_start = 1'b0;
        sof_valid    = 1'b0;
        sof_crc_ok   = 1'b0;
        sof_frame    = 11'h000;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic err(input int b);
        @(posedge clk_sys);
        err_ev[b] <= 1'b1;
        @(posedge clk_sys);
        err_ev[b] <= 1'b0;
    endtask : err

    task automatic resend();
        @(posedge clk_sys);
        resend_start <= 1'b1;
        @(posedge clk_sys);
        resend_start <= 1'b0;
    endtask : resend

    // Frame and status lines are scrambled outside the packet so a stale value never helps
    task automatic sof(input logic [10:0] f, input logic ok);
        @(posedge clk_sys);
        sof_valid  <= 1'b1;
        sof_crc_ok <= ok;
        sof_frame  <= f;
        @(posedge clk_sys);
        sof_valid  <= 1'b0;
        sof_crc_ok <= ~ok;
        sof_frame  <= ~f;
    endtask : sof

    // Error and resend in one cycle: the error must survive
    task automatic err_on_resend(input int b);
        @(posedge clk_sys);
        err_ev[b]    <= 1'b1;
        resend_start <= 1'b1;
        @(posedge clk_sys);
        err_ev[b]    <= 1'b0;
        resend_start <= 1'b0;
    endtask : err_on_resend
endmodule : uds_host_model

// file: testbench/uds_rx_status_tb.sv
/*
 * Self-checking bench for the receive status block: reset values, error flags,
 * buffer flags at both ends of every buffer, frame capture and bus reset.
 * Assumes register reads answer one cycle after the strobe; depths shrunk.
 */
module uds_rx_status_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SD = 4;
    localparam int LD = 8;

    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic        usb_bus_reset = 1'b0;
    logic        iso_mode = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [6:0]  buf_push = 7'h00;
    logic [6:0]  buf_pop = 7'h00;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wr_data = 8'h00;
    logic [7:0]  reg_rd_data;
    logic [3:0]  err_ev;
    logic        resend_start, sof_valid, sof_crc_ok;
    logic [10:0] sof_frame;
    int          errors = 0;
    int          n_checks = 0;
    int          cnt[7] = '{default: 0};

    always #5 clk_sys = ~clk_sys;

    uds_host_model host (.clk_sys(clk_sys), .err_ev(err_ev), .resend_start(resend_start),
        .sof_valid(sof_valid), .sof_crc_ok(sof_crc_ok), .sof_frame(sof_frame));

    uds_rx_status #(.SMALL_DEPTH(SD), .LARGE_DEPTH(LD)) uut (.clk_sys(clk_sys),
        .arst_n(arst_n), .usb_bus_reset(usb_bus_reset), .resend_start(resend_start),
        .pid_error(err_ev[3]), .addr_crc_error(err_ev[2]), .data_crc_error(err_ev[1]),
        .stuff_error(err_ev[0]), .buf_push(buf_push), .buf_pop(buf_pop),
        .iso_mode(iso_mode), .sof_valid(sof_valid), .sof_crc_ok(sof_crc_ok),
        .sof_frame(sof_frame), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        n_checks++;
        if (reg_rd_data !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, reg_rd_data);
        end
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr      <= 1'b1;
        reg_addr    <= a;
        reg_wr_data <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Full and empty reckoned from the bench's own byte counts
    task automatic chk_fifo();
        rd(8'h01, {4'h0, cnt[2] == 0, cnt[2] == SD, cnt[0] == 0, cnt[0] == SD}, "fifo_low");
        rd(8'h02, {2'h0, cnt[5] == 0 && cnt[6] == 0, cnt[5] == LD || cnt[6] == LD,
            cnt[3] == 0 && cnt[4] == 0, cnt[3] == SD || cnt[4] == SD,
            cnt[1] == 0, cnt[1] == SD}, "fifo_high");
    endtask : chk_fifo

    task automatic buf_ev(input int b, input logic push, input int d);
        @(posedge clk_sys);
        if (push) begin
            buf_push[b] <= 1'b1;
            if (cnt[b] < d) cnt[b]++;
        end else begin
            buf_pop[b] <= 1'b1;
            if (cnt[b] > 0) cnt[b]--;
        end
        @(posedge clk_sys);
        buf_push <= 7'h00;
        buf_pop  <= 7'h00;
    endtask : buf_ev

    task automatic chk_frame(input logic [10:0] f);
        rd(8'h03, {5'h00, f[10:8]}, "frame_high");
        rd(8'h04, f[7:0], "frame_low");
    endtask : chk_frame

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100us;
        errors++;
        $display("mismatch watchdog expected done seen timeout");
        end_sim();
    end

    initial begin
        int d;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(8'h00, 8'h00, "pkt_err");
        chk_fifo();
        chk_frame(11'h000);
        rd(8'h05, 8'h00, "unmapped");
        $display("test reset_values done");
        for (int i = 0; i < 4; i++) begin
            host.err(i);
            rd(8'h00, 8'h01 << i, "pkt_err_set");
            host.resend();
            rd(8'h00, 8'h00, "pkt_err_clr");
        end
        for (int i = 0; i < 4; i++) host.err(i);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h0F, "pkt_err_wr");
        host.resend();
        host.err_on_resend(3);
        rd(8'h00, 8'h08, "pkt_err_set_wins");
        host.resend();
        rd(8'h00, 8'h00, "pkt_err_clr_again");
        $display("test error_flags done");
        // One past full and one past empty, each dropped extra must not move a flag
        for (int b = 0; b < 7; b++) begin
            d = (b >= 5) ? LD : SD;
            for (int k = 0; k <= d; k++) begin
                buf_ev(b, 1'b1, d);
                chk_fifo();
            end
            wr(8'h01, 8'hFF);
            wr(8'h02, 8'h00);
            chk_fifo();
            for (int k = 0; k <= d; k++) begin
                buf_ev(b, 1'b0, d);
                chk_fifo();
            end
        end
        $display("test fifo_flags done");
        iso_mode <= 1'b1;
        host.sof(11'h5A3, 1'b1);
        chk_frame(11'h5A3);
        host.sof(11'h2C1, 1'b0);
        chk_frame(11'h5A3);
        iso_mode <= 1'b0;
        host.sof(11'h0FF, 1'b1);
        chk_frame(11'h5A3);
        iso_mode <= 1'b1;
        host.sof(11'h7FF, 1'b1);
        wr(8'h03, 8'h00);
        wr(8'h04, 8'h00);
        chk_frame(11'h7FF);
        $display("test frame_number done");
        host.err(3);
        buf_ev(0, 1'b1, SD);
        buf_ev(6, 1'b1, LD);
        @(posedge clk_sys);
        usb_bus_reset <= 1'b1;
        @(posedge clk_sys);
        usb_bus_reset <= 1'b0;
        cnt = '{default: 0};
        rd(8'h00, 8'h00, "pkt_err_busrst");
        chk_fifo();
        chk_frame(11'h000);
        $display("test bus_reset done");
        end_sim();
    end
endmodule : uds_rx_status_tb
